/* File: rmap_alias_remap.sv */
// rmap_alias_remap: alias decoders, address translation and register file
// assumes one clock, synchronous inputs, classic wishbone single cycles
`timescale 1ns/10ps
module rmap_alias_remap #(
    parameter int NUM_ENTRIES = 8
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // wishbone slave
    input wire rmap_pkg::rmap_wb_req_t wb_req_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // local i2c transaction headers
    input wire rmap_pkg::rmap_i2c_req_t i2c_req_in,
    // forwarded headers and local answers
    output rmap_pkg::rmap_fwd_t fwd_out,
    output logic auto_ack_out,
    output logic miss_out
);
    import rmap_pkg::*;

    // true when idx addresses entry n of a table starting at base
    function automatic logic idx_hit(input logic [7:0] idx,
                                     input logic [7:0] base,
                                     input int n);
        idx_hit = (idx == 8'(base + 8'(n)));
    endfunction : idx_hit

    logic [7:0] phys_q [NUM_ENTRIES];
    logic [7:0] alias_q [NUM_ENTRIES];
    logic ack_q;
    logic [31:0] dat_q;
    rmap_fwd_t fwd_q;
    logic auto_ack_q;
    logic miss_q;

    // bus decode
    wire logic [7:0] bus_idx = wb_req_in.adr[RMAP_IDX_LSB +: 8];
    wire logic bus_req = wb_req_in.cyc & wb_req_in.stb;
    wire logic bus_wr = bus_req & wb_req_in.we & ack_q & wb_req_in.sel[0];
    logic [NUM_ENTRIES-1:0] phys_sel;
    logic [NUM_ENTRIES-1:0] alias_sel;
    logic [NUM_ENTRIES-1:0] hit;

    // per-entry decoders and registers
    for (genvar n = 0; n < NUM_ENTRIES; n++) begin : g_ent
        assign phys_sel[n] = idx_hit(bus_idx, RMAP_PHYS_BASE_IDX, n);
        assign alias_sel[n] = idx_hit(bus_idx, RMAP_ALIAS_BASE_IDX, n);
        // nonzero alias equal to incoming address
        assign hit[n] = (alias_q[n][RMAP_ADDR_MSB:RMAP_ADDR_LSB]
                         != RMAP_ALIAS_OFF)
                        && (alias_q[n][RMAP_ADDR_MSB:RMAP_ADDR_LSB]
                         == i2c_req_in.addr);

        // physical address register, bit 0 held at zero
        always_ff @(posedge clk_in) begin
            if (reset_in) begin
                phys_q[n] <= RMAP_PHYS_RST;
            end else if (ce_in && bus_wr && phys_sel[n]) begin
                phys_q[n] <= {wb_req_in.dat[7:1], 1'b0};
            end
        end

        // alias address and auto-ack register
        always_ff @(posedge clk_in) begin
            if (reset_in) begin
                alias_q[n] <= RMAP_ALIAS_RST;
            end else if (ce_in && bus_wr && alias_sel[n]) begin
                alias_q[n] <= wb_req_in.dat[7:0];
            end
        end
    end

    // lowest matching entry wins
    logic [2:0] hit_idx;
    always_comb begin
        hit_idx = 3'h0;
        for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = 3'(i);
            end
        end
    end
    wire logic any_hit = |hit;
    wire logic [7:0] hit_phys = phys_q[hit_idx];
    wire logic hit_autoack = alias_q[hit_idx][RMAP_AUTOACK_BIT];

    // read mux; unmapped reads return zero
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            if (phys_sel[i]) begin
                rd_byte = phys_q[i];
            end
            if (alias_sel[i]) begin
                rd_byte = alias_q[i];
            end
        end
    end

    // wishbone answer: ack one cycle after the request, then drop
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else if (ce_in) begin
            ack_q <= bus_req & ~ack_q;
            dat_q <= {24'h00_0000, rd_byte};
        end
    end

    // translation stage: rewrite and forward (auto-ack writes also answered locally), or drop
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            fwd_q <= '0;
            auto_ack_q <= 1'b0;
            miss_q <= 1'b0;
        end else if (ce_in) begin
            fwd_q.valid <= i2c_req_in.valid & any_hit;
            fwd_q.addr <= hit_phys[RMAP_ADDR_MSB:RMAP_ADDR_LSB];
            fwd_q.rnw <= i2c_req_in.rnw;
            fwd_q.entry <= hit_idx;
            auto_ack_q <= i2c_req_in.valid & any_hit
                          & ~i2c_req_in.rnw & hit_autoack;
            miss_q <= i2c_req_in.valid & ~any_hit;
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = dat_q;
    assign fwd_out = fwd_q;
    assign auto_ack_out = auto_ack_q;
    assign miss_out = miss_q;

    // assertions
    sequence s_req_hit;
        ce_in && i2c_req_in.valid && any_hit;
    endsequence
    // taken write header to an entry with auto-ack set
    wire logic aa_wr = ce_in & i2c_req_in.valid & any_hit
                       & ~i2c_req_in.rnw & hit_autoack;

    chk_phys_bit_zero: assert property (@(posedge clk_in)
        disable iff (reset_in)
        ack_q && !wb_req_in.we && |phys_sel |-> !dat_q[0])
        else $error("physical address bit 0 read as one");

    chk_remap_addr: assert property (@(posedge clk_in)
        disable iff (reset_in)
        s_req_hit |=> fwd_q.valid
            && fwd_q.addr == $past(hit_phys[7:1]))
        else $error("forwarded address is not the physical address");

    chk_alias_store: assert property (@(posedge clk_in)
        disable iff (reset_in)
        ce_in && bus_wr && alias_sel[0] |=>
            alias_q[0] == $past(wb_req_in.dat[7:0]))
        else $error("alias register did not take the write");

    chk_zero_disable: assert property (@(posedge clk_in)
        disable iff (reset_in)
        ce_in && i2c_req_in.valid && i2c_req_in.addr == RMAP_ALIAS_OFF
            |=> !fwd_q.valid)
        else $error("zero alias forwarded a transaction");

    chk_auto_ack_write: assert property (@(posedge clk_in)
        disable iff (reset_in)
        aa_wr |=> auto_ack_out)
        else $error("auto-ack write was not acknowledged");

    chk_auto_ack_off: assert property (@(posedge clk_in)
        disable iff (reset_in)
        ce_in && !aa_wr |=> !auto_ack_out)
        else $error("acknowledge without auto-ack write");

    chk_pair_index: assert property (@(posedge clk_in)
        disable iff (reset_in)
        s_req_hit |=> fwd_q.entry == $past(hit_idx)
            && $past(hit[hit_idx]))
        else $error("entry index did not pair with its alias");

    chk_miss_drop: assert property (@(posedge clk_in)
        disable iff (reset_in)
        ce_in && i2c_req_in.valid && !any_hit |=> miss_out && !fwd_q.valid)
        else $error("unmatched address was forwarded");

    chk_ack_single: assert property (@(posedge clk_in)
        disable iff (reset_in)
        ce_in && ack_q |=> !ack_q)
        else $error("wishbone ack held two cycles");
endmodule : rmap_alias_remap

/* File: rmap_i2c_host.sv */
// rmap_i2c_host: local i2c controller model issuing headers
// assumes headers are sampled on the rising edge of clk_in
`timescale 1ns/10ps
module rmap_i2c_host (
    // clock
    input wire logic clk_in,
    // header toward the remap block
    output rmap_pkg::rmap_i2c_req_t req_out
);
    import rmap_pkg::*;
    // idle until the first header
    initial req_out = '0;
    // one header pulse; idle fields flip so stale values never match
    task automatic send(input logic [6:0] a, input logic r);
        req_out <= '{valid: 1'b1, addr: a, rnw: r};
        @(posedge clk_in);
        req_out <= '{valid: 1'b0, addr: ~a, rnw: ~r};
    endtask : send
endmodule : rmap_i2c_host

/* File: rmap_pkg.sv */
// rmap_pkg: constants and carrier types for the alias remap block
// assumes a classic wishbone master with byte addresses, word per register
package rmap_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] RMAP_PHYS4_IDX = 8'h3d;
    localparam logic [7:0] RMAP_PHYS5_IDX = 8'h3e;
    localparam logic [7:0] RMAP_PHYS6_IDX = 8'h3f;
    localparam logic [7:0] RMAP_PHYS7_IDX = 8'h40;
    localparam logic [7:0] RMAP_ALIAS0_IDX = 8'h41;
    // first physical entry index (entry n at base plus n)
    localparam logic [7:0] RMAP_PHYS_BASE_IDX = 8'h39;
    localparam logic [7:0] RMAP_ALIAS_BASE_IDX = RMAP_ALIAS0_IDX;
    // field layout
    localparam int RMAP_ADDR_MSB = 7;
    localparam int RMAP_ADDR_LSB = 1;
    localparam int RMAP_AUTOACK_BIT = 0;
    // values after reset, and the alias value that disables an entry
    localparam logic [7:0] RMAP_PHYS_RST = 8'h00;
    localparam logic [7:0] RMAP_ALIAS_RST = 8'h00;
    localparam logic [6:0] RMAP_ALIAS_OFF = 7'h00;
    // lowest bit of the index field in the wishbone address
    localparam int RMAP_IDX_LSB = 2;

    // wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } rmap_wb_req_t;

    // local i2c transaction header seen by the decoder
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic rnw;
    } rmap_i2c_req_t;

    // header forwarded to the control channel
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic rnw;
        logic [2:0] entry;
    } rmap_fwd_t;
endpackage : rmap_pkg

/* File: testbench.sv */
// testbench: register and alias remap checks for rmap_alias_remap
// assumes the i2c host model and classic wishbone single cycles
`timescale 1ns/10ps
module testbench;
    import rmap_pkg::*;
    logic clk_in, reset_in, wb_ack, auto_ack, miss, ce;
    logic [31:0] wb_dat, rd_data;
    rmap_wb_req_t wb_req;
    rmap_i2c_req_t i2c_req;
    rmap_fwd_t fwd;
    int n_mismatch = 0;
    int compares = 0;
    rmap_alias_remap u_rmap_alias_remap (.clk_in(clk_in),
        .reset_in(reset_in), .ce_in(ce), .wb_req_in(wb_req),
        .wb_dat_out(wb_dat), .wb_ack_out(wb_ack), .i2c_req_in(i2c_req),
        .fwd_out(fwd), .auto_ack_out(auto_ack), .miss_out(miss));
    rmap_i2c_host u_rmap_i2c_host (.clk_in(clk_in), .req_out(i2c_req));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one wishbone cycle; read data taken at the ack edge
    // waits for ack without a limit; the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] i,
                       input logic [7:0] d);
        wb_req <= '{1'b1, 1'b1, w, 4'hf, {22'h0, i, 2'h0}, {24'h0, d}};
        do begin
            @(posedge clk_in);
        end while (wb_ack !== 1'b1);
        rd_data = wb_dat;
        wb_req <= '0;
        @(posedge clk_in);
    endtask : bus
    // one header, answer checked one cycle later
    task automatic hdr(input logic [6:0] a, input logic r, input logic v,
                       input logic [9:0] pe, input logic aa);
        u_rmap_i2c_host.send(a, r);
        #1;
        chk({fwd.valid, auto_ack, miss}, {v, aa, ~v});
        if (v)
            chk({fwd.addr, fwd.rnw, fwd.entry},
                {pe[9:3], r, pe[2:0]});
        @(posedge clk_in);
    endtask : hdr
    // verdict and end of run
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    // 50 MHz clock
    initial begin
        clk_in = 0;
        forever #10 clk_in = ~clk_in;
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge clk_in);
        n_mismatch++;
        end_sim();
    end
    // test sequence
    initial begin
        reset_in = 1;
        ce = 1;
        wb_req = '0;
        repeat (20) @(posedge clk_in);
        reset_in <= 0;
        @(posedge clk_in);
        for (int i = 8'h3d; i <= 8'h41; i++) begin
            bus(0, i[7:0], 0);
            chk(rd_data, 0);
        end
        $display("test reset values done");
        for (int n = 4; n < 8; n++) begin
            bus(1, 8'h39 + n[7:0], 8'hff);
            bus(0, 8'h39 + n[7:0], 0);
            chk(rd_data, 32'h0000_00fe);
            bus(1, 8'h39 + n[7:0], {7'h10 + n[6:0], 1'b1});
            hdr(7'h20 + n[6:0], 0, 0, 0, 0);
            bus(1, 8'h41 + n[7:0], {7'h20 + n[6:0], 1'b0});
            hdr(7'h20 + n[6:0], 0, 1, {7'h10 + n[6:0], n[2:0]}, 0);
        end
        $display("test translation done");
        bus(1, 8'h39, 8'h54);
        bus(1, 8'h41, 8'h61);
        bus(0, 8'h41, 0);
        chk(rd_data, 32'h0000_0061);
        hdr(7'h30, 0, 1, {7'h2a, 3'h0}, 1);
        hdr(7'h30, 1, 1, {7'h2a, 3'h0}, 0);
        bus(1, 8'h41, 8'h00);
        hdr(7'h30, 0, 0, 0, 0);
        hdr(7'h00, 0, 0, 0, 0);
        bus(1, 8'h20, 8'h5a);
        bus(0, 8'h20, 0);
        chk(rd_data, 0);
        $display("test auto ack and unmapped done");
        // enable low: a header that would hit alias 5 is not taken
        ce <= 1'b0;
        u_rmap_i2c_host.send(7'h25, 1'b0);
        #1;
        chk({fwd.valid, auto_ack, miss}, 0);
        @(posedge clk_in);
        ce <= 1'b1;
        @(posedge clk_in);
        $display("test clock enable done");
        end_sim();
    end
endmodule : testbench
